// >>> core/olp_macrocells.sv
`timescale 1ns/1ps
// =====================================================================
// Summary of operation
// - Each preload clock loads every output register from its own pin, so one sequence can load all registers.
// - With preload enable high, a clock pulse loads each register from its forced pin level.
// - After preload an active-high registered cell's pin shows the stored register state and an active-low one its inverse, so the load can be checked.
// - Power-up clears every output register to zero without a clock edge.
// - After clear the pin level follows the programmed polarity, not the raw register.
// - Power-up clear acts on registered outputs only; combinational outputs are untouched.
// - After clear an active-low registered output reads high and an active-high one low.
// - Select 00/01 registered low/high with register feedback, 10/11 combinational with pin feedback.
module olp_macrocells (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic array_clk,
    input wire logic preload_supervoltage_level,
    input wire olp_pkg::olp_sel_t [olp_pkg::OLP_CELLS-1:0] sel,
    input wire logic [olp_pkg::OLP_CELLS-1:0] array_sum,
    input wire logic [olp_pkg::OLP_CELLS-1:0] array_oe,
    input wire logic [olp_pkg::OLP_CELLS-1:0] pin_i,
    output olp_pkg::olp_pin_out_t pins,
    output logic [olp_pkg::OLP_CELLS-1:0] feedback,
    output logic preload_active
);
    import olp_pkg::*;

    olp_state_t state_reg;
    olp_state_t state_next;
    logic clk_rise;

    // Pin level for a cell from its mode and the two data sources
    function automatic logic cell_level(input olp_sel_t s, input logic q, input logic comb);
        logic d;
        d = s.feedback_select_fuse ? comb : q;
        return s.polarity_select_fuse ? d : ~d;
    endfunction

    // =================================================================
    // Next state
    // Preload and array clock are pins, so both are double synchronised;
    // edges are found on the second stage only.
    // A third flop holds the previous synced clock level, so that the first
    // stage, which may still be metastable, never feeds the edge detector.
    // Cost: one more cycle of latency from pin edge to register load.
    always_comb begin
        state_next = state_reg;
        state_next.pre_sync = {state_reg.pre_sync[0], preload_supervoltage_level};
        state_next.clk_sync = {state_reg.clk_sync[0], array_clk};
        state_next.clk_prev = state_reg.clk_sync[1];
        state_next.pin_s1 = pin_i;
        state_next.pin_s2 = state_reg.pin_s1;
        clk_rise = state_reg.clk_sync[1] & ~state_reg.clk_prev;
        for (int i = 0; i < OLP_CELLS; i++) begin
            if (clk_rise) begin
                if (state_reg.pre_sync[1]) begin
                    // Every cell loads from its pin; only a forced pin gives a known level
                    state_next.q[i] = state_reg.pin_s2[i];
                end else if (!sel[i].feedback_select_fuse) begin
                    state_next.q[i] = array_sum[i];
                end
            end
        end
    end

    // =================================================================
    // State register; the async clear stands for power-up reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // =================================================================
    // Pin drive, feedback and preload flag
    always_comb begin
        preload_active = state_reg.pre_sync[1];
        for (int i = 0; i < OLP_CELLS; i++) begin
            // Polarity applies to the register, so a cleared cell reads per fuse
            pins.o[i] = cell_level(sel[i], state_reg.q[i], array_sum[i]);
            // Drivers off during preload to avoid contention with the tester
            pins.oe[i] = array_oe[i] & ~state_reg.pre_sync[1];
            // Registered cells feed back the register, combinational the pin
            feedback[i] = sel[i].feedback_select_fuse ? state_reg.pin_s2[i]
                                                      : state_reg.q[i];
        end
    end

    // =================================================================
    // Checks
    sequence preload_edge_s;
        $rose(state_reg.clk_sync[1]) && state_reg.pre_sync[1];
    endsequence

    property preload_load_p;
        @(posedge sys_clk) disable iff (!nrst)
        preload_edge_s |=> (state_reg.q == $past(state_reg.pin_s2));
    endproperty

    preload_load_a: assert property (preload_load_p)
        else $error("preload did not load register from pin");

    drivers_off_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        preload_active |-> (pins.oe == '0))
        else $error("driver enabled during preload");

    comb_hold_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (!state_reg.pre_sync[1] && sel[2].feedback_select_fuse) |=>
            (state_reg.q[2] == $past(state_reg.q[2])))
        else $error("combinational cell register changed");

    pin_shows_reg_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (sel[1] == OLP_MODE_REG_HIGH) |-> (pins.o[1] == state_reg.q[1]))
        else $error("pin does not show register");

    clear_level_a: assert property (
        @(posedge sys_clk)
        ($rose(nrst) && sel[0] == OLP_MODE_REG_LOW) |-> pins.o[0])
        else $error("active-low output not high after clear");

    feedback_sel_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (sel[2] == OLP_MODE_COMB_LOW) |-> (feedback[2] == state_reg.pin_s2[2]))
        else $error("wrong feedback source");

    no_edge_hold_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !$rose(state_reg.clk_sync[1]) |=> (state_reg.q == $past(state_reg.q)))
        else $error("register changed without clock");

    polarity_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (sel[3] == OLP_MODE_COMB_HIGH) |-> (pins.o[3] == array_sum[3]))
        else $error("polarity not applied");

    // =================================================================
    // Multi-step checks: clear release, normal clocking, preload exit
    // Cells named by index follow the fuse pattern the checks expect;
    // each property is guarded by its own fuse test where that matters.
    sequence clear_release_s;
        $rose(nrst);
    endsequence

    sequence normal_edge_s;
        $rose(state_reg.clk_sync[1]) && !state_reg.pre_sync[1];
    endsequence

    sequence preload_exit_s;
        $fell(state_reg.pre_sync[1]);
    endsequence

    // Every register is zero right after the power-up clear lets go
    clear_regs_a: assert property (
        @(posedge sys_clk)
        clear_release_s |-> (state_reg.q == '0))
        else $error("register not cleared at power-up");

    // Active-high registered output reads low after the clear
    clear_high_a: assert property (
        @(posedge sys_clk)
        ($rose(nrst) && sel[1] == OLP_MODE_REG_HIGH) |-> !pins.o[1])
        else $error("active-high output not low after clear");

    // Combinational output keeps following the array through the clear
    clear_comb_a: assert property (
        @(posedge sys_clk)
        ($rose(nrst) && sel[2] == OLP_MODE_COMB_LOW) |-> (pins.o[2] == !array_sum[2]))
        else $error("combinational output disturbed by clear");

    // Registered feedback is zero after the clear
    clear_fb_a: assert property (
        @(posedge sys_clk)
        ($rose(nrst) && !sel[0].feedback_select_fuse) |-> !feedback[0])
        else $error("registered feedback not zero after clear");

    // Normal clocking loads a registered cell from its array sum
    normal_load_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        normal_edge_s |=>
            (sel[1].feedback_select_fuse || (state_reg.q[1] == $past(array_sum[1]))))
        else $error("registered cell not loaded from array");

    // Normal clocking leaves a combinational cell's register alone
    comb_no_load_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        normal_edge_s |=>
            (!sel[2].feedback_select_fuse || (state_reg.q[2] == $past(state_reg.q[2]))))
        else $error("combinational register clocked");

    // Drivers come back as soon as preload is left
    exit_drive_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        preload_exit_s |-> (pins.oe == array_oe))
        else $error("drivers not restored after preload");

    // Outside preload the enables are the array terms
    oe_follow_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !preload_active |-> (pins.oe == array_oe))
        else $error("enable does not follow array");

    // Registered cells feed back their register
    reg_feedback_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !sel[0].feedback_select_fuse |-> (feedback[0] == state_reg.q[0]))
        else $error("registered feedback wrong");

    // Active-low registered pin is the inverse of the register
    active_low_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (sel[0] == OLP_MODE_REG_LOW) |-> (pins.o[0] == !state_reg.q[0]))
        else $error("active-low polarity not applied");

    // Combinational high cell feeds back its pin
    comb_feedback_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        (sel[3] == OLP_MODE_COMB_HIGH) |-> (feedback[3] == state_reg.pin_s2[3]))
        else $error("pin feedback wrong");
endmodule

// >>> core/olp_pkg.sv
package olp_pkg;
    // Number of output macrocells
    localparam int OLP_CELLS = 10;
    // Fuse select encodings: {feedback_select_fuse, polarity_select_fuse}
    localparam logic [1:0] OLP_MODE_REG_LOW = 2'h0;
    localparam logic [1:0] OLP_MODE_REG_HIGH = 2'h1;
    localparam logic [1:0] OLP_MODE_COMB_LOW = 2'h2;
    localparam logic [1:0] OLP_MODE_COMB_HIGH = 2'h3;
    // Bit positions inside a select pair
    localparam int OLP_POL_BIT = 0;
    localparam int OLP_FB_BIT = 1;
    // Register value after power-up clear
    localparam logic OLP_CLEAR_VALUE = 1'h0;
    // Preload step timing and the clock period, in ns
    localparam int OLP_STEP_MIN_NS = 100;
    localparam int OLP_STEP_MAX_NS = 1000;
    localparam int OLP_CLK_PERIOD_NS = 25;
    localparam int OLP_STEP_MIN_CYC = (OLP_STEP_MIN_NS + OLP_CLK_PERIOD_NS - 1)
        / OLP_CLK_PERIOD_NS;
    localparam int OLP_STEP_MAX_CYC = OLP_STEP_MAX_NS / OLP_CLK_PERIOD_NS;

    // Per-cell fuse selects
    typedef struct packed {
        logic feedback_select_fuse;
        logic polarity_select_fuse;
    } olp_sel_t;

    // Pin group of one direction across all cells
    typedef struct packed {
        logic [OLP_CELLS-1:0] o;
        logic [OLP_CELLS-1:0] oe;
    } olp_pin_out_t;

    // All state of the block
    typedef struct packed {
        logic [1:0] pre_sync;
        logic [1:0] clk_sync;
        logic clk_prev;
        logic [OLP_CELLS-1:0] pin_s1;
        logic [OLP_CELLS-1:0] pin_s2;
        logic [OLP_CELLS-1:0] q;
    } olp_state_t;
endpackage

// >>> verification/olp_tester.sv
`timescale 1ns/1ps
// =====================
// Preload tester model
module olp_tester (
    input wire logic sys_clk,
    output logic array_clk,
    output logic pre,
    output logic [olp_pkg::OLP_CELLS-1:0] ext
);
    import olp_pkg::*;
    logic [OLP_CELLS-1:0] drv = '0;
    logic [OLP_CELLS-1:0] drv_en = '0;
    logic flt = 1'b0;
    // Clock pin and preload pin start low
    initial begin
        array_clk = 1'b0;
        pre = 1'b0;
    end
    // Released lines float, so show a level that changes every cycle
    always @(posedge sys_clk) flt <= ~flt;
    assign ext = (drv_en & drv) | (~drv_en & {OLP_CELLS{flt}});
    // Four cycles give 100 ns, the shortest legal step
    task automatic step;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic pulse;
        step();
        array_clk <= 1'b1;
        step();
        array_clk <= 1'b0;
        step();
    endtask
    // One forced pin per sequence, though the clock loads every register; forced pin released before preload drops
    task automatic preload(input int c, input logic v);
        @(posedge sys_clk);
        array_clk <= 1'b0;
        pre <= 1'b1;
        step();
        drv[c] <= v;
        drv_en[c] <= 1'b1;
        pulse();
        drv_en <= '0;
        step();
        pre <= 1'b0;
        step();
    endtask
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
    import olp_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    olp_sel_t [OLP_CELLS-1:0] sel;
    logic [OLP_CELLS-1:0] array_sum = '0;
    logic [OLP_CELLS-1:0] array_oe = '1;
    logic [OLP_CELLS-1:0] pin_i, ext, feedback, q_exp, regd;
    logic array_clk, pre, preload_active;
    olp_pin_out_t pins;
    int errors = 0;
    int checked = 0;
    always #12.5 sys_clk = ~sys_clk;
    // Wire level: the device wins while it drives, else the tester
    assign pin_i = (pins.oe & pins.o) | (~pins.oe & ext);
    olp_macrocells i_olp_macrocells(.sys_clk(sys_clk), .nrst(nrst), .array_clk(array_clk),
        .preload_supervoltage_level(pre), .sel(sel), .array_sum(array_sum),
        .array_oe(array_oe), .pin_i(pin_i), .pins(pins), .feedback(feedback),
        .preload_active(preload_active));
    olp_tester i_olp_tester(.sys_clk(sys_clk), .array_clk(array_clk), .pre(pre), .ext(ext));
    // ====================
    // Helpers
    function automatic logic [9:0] exp_o(input logic [9:0] q);
        for (int i = 0; i < OLP_CELLS; i++) begin
            exp_o[i] = (sel[i].feedback_select_fuse ? array_sum[i] : q[i])
                ^ ~sel[i].polarity_select_fuse;
        end
    endfunction
    task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize;
        if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ====================
    // Scenarios
    task automatic t_reset;
        q_exp = '0;
        @(posedge sys_clk) nrst <= 1'b0;
        #1 chk("clear pins", pins.o, exp_o(q_exp));
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("clear fb", feedback & regd, '0);
    endtask
    task automatic t_clock;
        @(posedge sys_clk) array_sum <= 10'h2b5;
        i_olp_tester.pulse();
        q_exp = 10'h2b5;
        repeat (4) @(posedge sys_clk);
        chk("run pins", pins.o, exp_o(q_exp));
        chk("run fb", feedback, (q_exp & regd) | (exp_o(q_exp) & ~regd));
    endtask
    // Array term of cell 1 stays 0, so loading a 1 proves the pin was used
    task automatic t_preload;
        fork
            i_olp_tester.preload(1, 1'b1);
            begin
                repeat (12) @(posedge sys_clk);
                chk("preload oe", pins.oe, '0);
                chk("preload flag", {9'h0, preload_active}, 10'h1);
            end
        join
        repeat (4) @(posedge sys_clk);
        chk("preload pin", {9'h0, pins.o[1]}, 10'h1);
        chk("post oe", pins.oe, array_oe);
    endtask
    initial begin
        for (int i = 0; i < OLP_CELLS; i++) begin
            sel[i] = olp_sel_t'(2'(i % 4));
            regd[i] = ~sel[i].feedback_select_fuse;
        end
        t_reset();
        t_clock();
        t_preload();
        t_reset();
        summarize();
    end
    // Watchdog against a hung run
    initial begin
        #200us errors++;
        summarize();
    end
endmodule
